// ### core/iacs_regs.svh
`ifndef IACS_REGS_SVH
`define IACS_REGS_SVH
// ************************************************************
// timing and field constants
// ************************************************************
// conversion clock rate in hz (20 mhz)
`define IACS_CLK_HZ 20000000
// pipeline depth and total sample-to-output latency in cycles
`define IACS_PIPE_DEPTH 12
`define IACS_LATENCY 15
// calibration times in ms, nominal and longest
`define IACS_CAL_NOM_MS 200
`define IACS_CAL_MAX_MS 550
// cycles for nominal calibration, rounded down so it stays within the longest time
`define IACS_CAL_CYCLES ((`IACS_CLK_HZ / 1000) * `IACS_CAL_NOM_MS)
// longest calibration in cycles
`define IACS_CAL_MAX_CYCLES ((`IACS_CLK_HZ / 1000) * `IACS_CAL_MAX_MS)
// sample width
`define IACS_DATA_W 10
// divider select codes: low, floating, high
`define IACS_DIV_PIN_LOW 2'h0
`define IACS_DIV_PIN_FLOAT 2'h1
`define IACS_DIV_PIN_HIGH 2'h2
// output fifo
`define IACS_FIFO_DEPTH 32
`endif

// ### core/iacs_pkg.sv
package iacs_pkg;
  // calibration sequencer states
  typedef enum logic [1:0] {
    IACS_ST_RESET = 2'b00, // trigger held low
    IACS_ST_CAL = 2'b01, // calibrating, inputs disconnected
    IACS_ST_RUN = 2'b10 // normal conversion
  } iacs_state_t;
endpackage

// ### core/iacs_fifo.sv
`timescale 1ns/100ps
// ************************************************************
// sample fifo, valid/ready on both sides
// ************************************************************
module iacs_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr; // write pointer with wrap bit
    logic [AW:0] rd; // read pointer with wrap bit
  } iacs_fifo_st_t;
  iacs_fifo_st_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH]; // storage, not reset to save area
  logic full, empty, push, pop;
  // flags from pointer compare
  always_comb begin
    empty = (st_reg.wr == st_reg.rd);
    full = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
    push = ce && in_valid && !full;
    pop = ce && out_ready && !empty;
    st_next = st_reg;
    if (push) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st_reg.rd[AW-1:0]];
  // pointer register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (push) begin
      mem[st_reg.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// ### core/iacs_core.sv
`timescale 1ns/100ps
`include "iacs_regs.svh"
// How it works
// - samples leave the latency line fifteen cycles after capture at full rate
// - cores alternate on successive conversion edges
// - gain, offset, skew trims; calibration skips skew
// - calibration disconnects input, then loads trims
// - power-up calibration starts once supplies good
// - calibration begins on trigger rising edge
// - over-range forced high from trigger low
// - real over-range still wins after calibration
// - output clock low while trigger low
// - calibration nominal 200ms, under 550ms
// - divider pin: low halves, float passes, high barred
// - serial divider setting overrides the pin
// - edge dropping only in divide-by-two
// - serial settings cross domains via synchronisers
module iacs_core #(
  parameter int CAL_CYCLES = `IACS_CAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic recal_trigger_n,
  input wire logic supplies_good,
  input wire logic [1:0] divider_select_pin,
  input wire logic spi_div_override,
  input wire logic spi_div_by2,
  input wire logic edge_drop_req,
  input wire logic [7:0] spi_gain_trim,
  input wire logic [7:0] spi_offset_trim,
  input wire logic [7:0] spi_skew_trim,
  input wire logic [9:0] analog_sample,
  input wire logic analog_over_range,
  input wire logic serial_readback_line,
  output logic output_sample_clock,
  output logic [9:0] sample_data,
  output logic over_range,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic sample_overflow,
  output logic input_disconnect,
  output logic core_sel,
  output logic cal_done,
  output logic div_by2_active,
  output logic div_pin_error,
  output logic [7:0] gain_trim,
  output logic [7:0] offset_trim,
  output logic [7:0] skew_trim
);
  // ************************************************************
  // state
  // ************************************************************
  localparam int CW = $clog2(`IACS_CAL_MAX_CYCLES + 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
  localparam int LW = `IACS_DATA_W + 1;
  typedef struct packed {
    iacs_pkg::iacs_state_t st; // sequencer state
    logic [1:0] trig_s; // trigger synchroniser
    logic [1:0] sup_s; // supply detector synchroniser
    logic [1:0] div_s0; // pin synchroniser, first stage
    logic [1:0] div_s1; // pin synchroniser, second stage
    logic [2:0] ovr_s0; // override, by2, drop, first stage
    logic [2:0] ovr_s1; // second stage
    logic [23:0] trim_s0; // trims first stage
    logic [23:0] trim_s1; // trims second stage
    logic [1:0] an_or_s; // over-range synchroniser
    logic trig_prev; // for rising edge detect
    logic por_done; // power-up calibration launched
    logic [CW-1:0] cal_cnt; // calibration cycle count
    logic div_ph; // divide-by-two phase
    logic core; // active core
    logic oclk; // output sample clock
    logic [LW*`IACS_LATENCY-1:0] pipe; // latency line, {or,data} words
    logic [`IACS_LATENCY-1:0] pv; // valid line
    logic [7:0] g, o, k; // applied trims
    logic dn; // calibration done
    logic ovf; // fifo overflow sticky
    logic orr; // over-range output
    logic disc; // input disconnected, registered for a clean pin
    logic d2; // divide-by-two in force, registered
    logic perr; // barred divider pin level seen, registered
  } iacs_st_t;
  iacs_st_t s_reg, s_next;
  logic f_in_ready;
  logic f_valid;
  logic [LW-1:0] f_data;
  logic sel_by2;
  logic adv;
  logic trig_rise;
  // ************************************************************
  // helper: effective divide mode
  // ************************************************************
  function automatic logic div_mode(input logic ovr, input logic by2, input logic [1:0] pin);
    if (ovr) begin
      div_mode = by2;
    end else begin
      div_mode = (pin == `IACS_DIV_PIN_LOW);
    end
  endfunction
  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    // all external levels except analog_sample, sample_ready and the unread serial_readback_line go through two flip-flops
    s_next.trig_s = {s_reg.trig_s[0], recal_trigger_n};
    s_next.sup_s = {s_reg.sup_s[0], supplies_good};
    s_next.div_s0 = divider_select_pin;
    s_next.div_s1 = s_reg.div_s0;
    s_next.ovr_s0 = {spi_div_override, spi_div_by2, edge_drop_req};
    s_next.ovr_s1 = s_reg.ovr_s0;
    s_next.trim_s0 = {spi_gain_trim, spi_offset_trim, spi_skew_trim};
    s_next.trim_s1 = s_reg.trim_s0;
    s_next.an_or_s = {s_reg.an_or_s[0], analog_over_range};
    s_next.trig_prev = s_reg.trig_s[1];
    sel_by2 = div_mode(s_reg.ovr_s1[2], s_reg.ovr_s1[1], s_reg.div_s1);
    trig_rise = s_reg.trig_s[1] && !s_reg.trig_prev;
    // divider: by-two advances every other edge; edge drop only here
    adv = 1'b1;
    if (sel_by2) begin
      s_next.div_ph = s_reg.div_ph ^ !s_reg.ovr_s1[0];
      // a held drop request swallows edges rather than freezing on an advance
      adv = s_reg.div_ph && !s_reg.ovr_s1[0];
    end else begin
      s_next.div_ph = 1'b0;
    end
    s_next.oclk = 1'b0;
    s_next.pv = {s_reg.pv[`IACS_LATENCY-2:0], 1'b0};
    case (s_reg.st)
      iacs_pkg::IACS_ST_RESET: begin
        s_next.dn = 1'b0;
        s_next.cal_cnt = '0;
        // power-up waits for supplies, user recal for trigger edge
        if (trig_rise && (s_reg.sup_s[1] || s_reg.por_done)) begin
          s_next.st = iacs_pkg::IACS_ST_CAL;
          s_next.por_done = 1'b1;
        end
      end
      iacs_pkg::IACS_ST_CAL: begin
        s_next.cal_cnt = s_reg.cal_cnt + 1'b1;
        if (s_reg.cal_cnt == CAL_LAST) begin
          s_next.st = iacs_pkg::IACS_ST_RUN;
          s_next.dn = 1'b1;
          // calibration loads gain/offset only, skew stays serial
          s_next.g = s_reg.trim_s1[23:16];
          s_next.o = s_reg.trim_s1[15:8];
        end
      end
      iacs_pkg::IACS_ST_RUN: begin
        s_next.k = s_reg.trim_s1[7:0];
        if (adv) begin
          s_next.core = !s_reg.core;
          s_next.oclk = 1'b1;
          s_next.pipe = {s_reg.pipe[LW*(`IACS_LATENCY-1)-1:0],
                         s_reg.an_or_s[1], analog_sample};
          s_next.pv = {s_reg.pv[`IACS_LATENCY-2:0], 1'b1};
        end
      end
      default: begin
        s_next.st = iacs_pkg::IACS_ST_RESET;
      end
    endcase
    // low trigger aborts anything and restarts
    if (!s_reg.trig_s[1]) begin
      s_next.st = iacs_pkg::IACS_ST_RESET;
      s_next.oclk = 1'b0;
    end
    // forced high outside run, real flag afterwards
    if (s_next.st != iacs_pkg::IACS_ST_RUN) begin
      s_next.orr = 1'b1;
    end else if (s_reg.pv[`IACS_LATENCY-1]) begin
      s_next.orr = s_reg.pipe[LW*`IACS_LATENCY-1];
    end
    // output flags registered so each of these flag pins leaves a flip-flop
    s_next.disc = (s_next.st != iacs_pkg::IACS_ST_RUN);
    s_next.d2 = sel_by2;
    s_next.perr = (s_reg.div_s1 == `IACS_DIV_PIN_HIGH);
    // no back-pressure upstream of a converter: overflow is sticky
    if (s_reg.pv[`IACS_LATENCY-1] && !f_in_ready) begin
      s_next.ovf = 1'b1;
    end
  end
  // ************************************************************
  // register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= iacs_pkg::IACS_ST_RESET;
      s_reg.orr <= 1'b1;
      s_reg.disc <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  // output fifo on the sample path
  iacs_fifo #(.WIDTH(LW), .DEPTH(`IACS_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data(s_reg.pipe[LW*`IACS_LATENCY-1 -: LW]),
    .in_valid(s_reg.pv[`IACS_LATENCY-1]),
    .in_ready(f_in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(sample_ready)
  );
  // ************************************************************
  // outputs
  // ************************************************************
  assign output_sample_clock = s_reg.oclk;
  assign over_range = s_reg.orr;
  assign sample_data = f_data[9:0];
  assign sample_valid = f_valid;
  assign sample_overflow = s_reg.ovf;
  assign input_disconnect = s_reg.disc;
  assign core_sel = s_reg.core;
  assign cal_done = s_reg.dn;
  assign div_by2_active = s_reg.d2;
  assign div_pin_error = s_reg.perr;
  assign gain_trim = s_reg.g;
  assign offset_trim = s_reg.o;
  assign skew_trim = s_reg.k;
  // ************************************************************
  // checks
  // ************************************************************
  sequence seq_cal_end;
    s_reg.st == iacs_pkg::IACS_ST_CAL && s_reg.cal_cnt == CAL_LAST && s_reg.trig_s[1];
  endsequence
  a_or_forced: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.st != iacs_pkg::IACS_ST_RUN |-> over_range) else $error("over-range not forced");
  a_oclk_low: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !s_reg.trig_s[1]) |=> !output_sample_clock) else $error("output clock not low");
  a_cal_start: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && s_reg.st == iacs_pkg::IACS_ST_CAL) |-> $past(s_reg.trig_s[1]))
    else $error("calibration without trigger high");
  a_cal_done: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_cal_end and ce) |=> cal_done) else $error("done missing at count end");
  a_core_alt: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && s_reg.st == iacs_pkg::IACS_ST_RUN && s_reg.trig_s[1] && adv) |=>
    core_sel != $past(core_sel)) else $error("cores not alternating");
  a_div_override: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && s_reg.ovr_s1[2]) |=> div_by2_active == $past(s_reg.ovr_s1[1]))
    else $error("override lost");
  a_disconnect: assert property (@(posedge clk) disable iff (!rst_n)
    s_reg.st == iacs_pkg::IACS_ST_CAL |-> input_disconnect && !cal_done)
    else $error("input connected during calibration");
  a_latency: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && s_reg.pv[0]) |-> ##14 s_reg.pv[`IACS_LATENCY-1]) else $error("latency");
  a_skew_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_cal_end and ce) |=> skew_trim == $past(skew_trim)) else $error("calibration moved skew");
endmodule

// ### dv/iacs_host_model.sv
`timescale 1ns/100ps
// ************************************************************
// host side: trigger driver and sample sink
// ************************************************************
module iacs_host_model (
  input wire logic clk,
  input wire logic hold_low,
  input wire logic stall,
  input wire logic sample_valid,
  output logic recal_trigger_n,
  output logic sample_ready,
  output logic serial_readback_line,
  output logic [31:0] taken
);
  // open drain: pull low, else the pull-up wins; starts low
  assign recal_trigger_n = hold_low ? 1'b0 : 1'b1;
  // readback line kept high; the core does not read it
  assign serial_readback_line = 1'b1;
  // sink may stall to back the fifo up
  assign sample_ready = ~stall;
  // count of words accepted
  initial taken = 32'h0;
  // one word per handshake edge
  always @(posedge clk) begin
    if (sample_valid && sample_ready) begin
      taken <= taken + 32'h1;
    end
  end
endmodule

// ### dv/interleaved_adc_cal_sequencer_bench.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module interleaved_adc_cal_sequencer_bench;
  localparam int CAL = 20; // short calibration, full count takes 200ms
  localparam int LAT = 15; // capture to output, in clock cycles
  // divider rows: pin, override, spi by-two, expected by-two, expected error
  typedef struct packed {logic [1:0] pin; logic ovr; logic by2; logic d2; logic err;} iacs_row_t;
  iacs_row_t rows [5] = '{'{2'h0, 1'b0, 1'b0, 1'b1, 1'b0}, '{2'h1, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h2, 1'b0, 1'b0, 1'b0, 1'b1}, '{2'h1, 1'b1, 1'b1, 1'b1, 1'b0},
    '{2'h0, 1'b1, 1'b0, 1'b0, 1'b0}};
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hold_low = 1'b1; // trigger begins low
  logic stall = 1'b0;
  logic supplies_good = 1'b0;
  logic [1:0] div_pin = 2'h1;
  logic spi_ovr = 1'b0;
  logic spi_by2 = 1'b0;
  logic [7:0] gain = 8'h3c;
  logic [7:0] offs = 8'hc3;
  logic [7:0] skew = 8'h00;
  logic [9:0] asamp = 10'h000;
  logic aor = 1'b0;
  logic drop = 1'b0;
  logic trig_n, rdb, sready, osc, orng, svalid, ovf, disc, csel, cdone, d2, derr;
  logic [9:0] sdata;
  logic [7:0] gt, ot, st;
  logic [31:0] taken;
  // free-running conversion clock, 50 ns
  always #25 clk = ~clk;
  iacs_core #(.CAL_CYCLES(CAL)) iacs_core_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .recal_trigger_n(trig_n), .supplies_good(supplies_good), .divider_select_pin(div_pin),
    .spi_div_override(spi_ovr), .spi_div_by2(spi_by2), .edge_drop_req(drop),
    .spi_gain_trim(gain), .spi_offset_trim(offs), .spi_skew_trim(skew),
    .analog_sample(asamp), .analog_over_range(aor), .serial_readback_line(rdb),
    .output_sample_clock(osc), .sample_data(sdata), .over_range(orng), .sample_valid(svalid),
    .sample_ready(sready), .sample_overflow(ovf), .input_disconnect(disc), .core_sel(csel),
    .cal_done(cdone), .div_by2_active(d2), .div_pin_error(derr), .gain_trim(gt),
    .offset_trim(ot), .skew_trim(st));
  iacs_host_model iacs_host_model_inst (.clk(clk), .hold_low(hold_low), .stall(stall),
    .sample_valid(svalid), .recal_trigger_n(trig_n), .sample_ready(sready),
    .serial_readback_line(rdb), .taken(taken));
  // ************************************************************
  // helpers
  // ************************************************************
  // inputs move on falling edges only
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait on calibration done
  task automatic wait_done(output int n);
    n = 0;
    while (cdone !== 1'b1 && n < 4 * CAL) begin
      cyc(1);
      n++;
    end
  endtask
  // one-cycle low pulse on the trigger line
  task automatic pulse();
    hold_low = 1'b1;
    cyc(1);
    hold_low = 1'b0;
  endtask
  // verdict, single exit point
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    int n;
    int m;
    logic a;
    logic [31:0] t0;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    `CHK("over_range", 1'b1, orng)
    `CHK("out clock", 1'b0, osc)
    `CHK("disconnect", 1'b1, disc)
    $display("test reset done");
    // power-up: supplies good, then trigger released to the pull-up
    supplies_good = 1'b1;
    cyc(4);
    hold_low = 1'b0;
    cyc(CAL / 2);
    `CHK("cal over_range", 1'b1, orng)
    `CHK("cal out clock", 1'b0, osc)
    `CHK("cal disconnect", 1'b1, disc)
    wait_done(n);
    n = n + CAL / 2;
    `CHK("cal length", 1'b1, (n >= CAL + 2 && n <= CAL + 5))
    `CHK("gain trim", gain, gt)
    `CHK("offset trim", offs, ot)
    skew = 8'ha5;
    cyc(5);
    `CHK("skew trim", 8'ha5, st)
    `CHK("run connect", 1'b0, disc)
    $display("test power-up calibration done");
    // divider table
    foreach (rows[i]) begin
      div_pin = rows[i].pin;
      spi_ovr = rows[i].ovr;
      spi_by2 = rows[i].by2;
      cyc(5);
      `CHK("div by two", rows[i].d2, d2)
      `CHK("div pin error", rows[i].err, derr)
    end
    // held drop request in divide-by-two: no output clock edges at all
    div_pin = 2'h0;
    spi_ovr = 1'b0;
    drop = 1'b1;
    cyc(4);
    m = 0;
    repeat (6) begin
      cyc(1);
      m = m + osc;
    end
    `CHK("edge drop", 0, m)
    drop = 1'b0;
    div_pin = 2'h1;
    cyc(LAT + 5);
    $display("test divider done");
    `CHK("run over_range", 1'b0, orng)
    a = csel;
    cyc(1);
    `CHK("core alternates", ~a, csel)
    asamp = 10'h155;
    cyc(1);
    asamp = 10'h000;
    n = 1;
    while (!(svalid === 1'b1 && sdata === 10'h155) && n < 40) begin
      cyc(1);
      n++;
    end
    `CHK("latency", LAT + 1, n)
    aor = 1'b1;
    cyc(LAT + 3);
    `CHK("run over_range high", 1'b1, orng)
    $display("test latency done");
    // recalibration with input over range, aborted once mid-way
    pulse();
    cyc(4);
    `CHK("recal over_range", 1'b1, orng)
    `CHK("recal done low", 1'b0, cdone)
    `CHK("recal out clock", 1'b0, osc)
    cyc(CAL / 2);
    pulse();
    wait_done(m);
    `CHK("abort restarts", 1'b1, (m >= CAL + 2 && m <= CAL + 5))
    cyc(LAT + 3);
    `CHK("over range hides end", 1'b1, orng)
    aor = 1'b0;
    cyc(LAT + 3);
    `CHK("over_range clears", 1'b0, orng)
    $display("test recalibration done");
    // stall the sink until the fifo refuses, then drain
    stall = 1'b1;
    cyc(50);
    `CHK("fifo holds", 1'b1, svalid)
    `CHK("overflow", 1'b1, ovf)
    t0 = taken;
    stall = 1'b0;
    cyc(40);
    `CHK("drained", 1'b1, (taken - t0 >= 32'd32))
    `CHK("overflow sticky", 1'b1, ovf)
    rst_n = 1'b0;
    cyc(2);
    `CHK("overflow reset", 1'b0, ovf)
    `CHK("reset over_range", 1'b1, orng)
    $display("test fifo done");
    results();
  end
endmodule
